// ===== icdr_pkg.sv
// Package for the two-wire bus configuration, interrupt and DMA block.
// Assumes 8-bit registers, one per aligned word of a 32-bit Wishbone bus.

package icdr_pkg;

  // ----------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------
  localparam logic [7:0] IDX_DIV = 8'hF3;
  localparam logic [7:0] IDX_OAR_LO = 8'hF4;
  localparam logic [7:0] IDX_OAR_HI = 8'hF5;
  localparam logic [7:0] IDX_DATA = 8'hF6;
  localparam logic [7:0] IDX_GCV = 8'hF7;
  localparam logic [7:0] IDX_ISR = 8'hF8;
  localparam logic [7:0] IDX_IVR = 8'hF9;
  localparam logic [7:0] IDX_RDAP = 8'hFA;
  localparam logic [7:0] IDX_DIVX = 8'hFE;

  // ----------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_GCV = 8'hA0;
  localparam logic [7:0] RST_ISR = 8'h80;

  // ----------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------
  localparam int DIV_SPEED = 7;
  localparam int OAR_TEN = 5;
  localparam int OAR_F2 = 4;
  localparam int ISR_SUSP = 7;
  localparam int ISR_ERR = 2;
  localparam int ISR_RX = 1;
  localparam int ISR_TX = 0;
  localparam logic [7:0] ADDR_NEVER = 8'h01;
  localparam logic [2:0] PRL_NONE = 3'h7;
  localparam logic [1:0] SRC_ERR = 2'h1;
  localparam logic [1:0] SRC_RX = 2'h2;
  localparam logic [1:0] SRC_TX = 2'h3;

  // Serial clock phase, Gray along the fast-mode path
  typedef enum logic [1:0] {
    SCL_LOW1 = 2'b00,
    SCL_LOW2 = 2'b01,
    SCL_HIGH = 2'b11
  } icdr_scl_t;

endpackage : icdr_pkg

// ===== icdr_regs.sv
// Configuration, interrupt and DMA control of a two-wire bus port.
// Assumes status flags, DMA masks and interrupt masks come from outside.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ns

module icdr_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic peripheral_enable_i,
  input wire logic global_interrupt_enable_i,
  input wire logic [7:0] error_flags_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic tx_ready_i,
  input wire logic rx_dma_done_i,
  input wire logic tx_dma_done_i,
  input wire logic rx_dma_mask_i,
  input wire logic tx_dma_mask_i,
  input wire logic [2:0] irq_mask_i,
  input wire logic addr_valid_i,
  input wire logic [9:0] bus_addr_i,
  input wire logic bus_addr_ten_i,
  output logic scl_o,
  output logic scl_tick_o,
  output logic [2:0] timing_range_select_o,
  output logic ten_bit_enable_o,
  output logic own_match_o,
  output logic gen_call_match_o,
  output logic [7:0] tx_byte_o,
  output logic tx_start_o,
  output logic rx_next_o,
  output logic rx_dma_req_o,
  output logic tx_dma_req_o,
  output logic irq_req_o,
  output logic [2:0] priority_level_o,
  output logic [6:0] rx_pointer_address_o,
  output logic rx_pointer_ext_select_o
);
  import icdr_pkg::*;

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  logic [7:0] div_reg; // Speed bit and low divider
  logic [1:0] divider_code_high; // Divider bits 8:7
  logic [7:0] own_address_low; // Own address low byte
  logic [7:0] oar_hi; // Range, ten-bit, high address
  logic [7:0] data_byte; // Data register
  logic [7:0] general_call_value; // General call address
  logic dma_suspend_select; // DMA suspended mode
  logic [2:0] priority_level; // Block priority
  logic error_pending; // Error pending
  logic receive_pending; // Receive pending
  logic transmit_pending; // Transmit pending
  logic [4:0] vector_base; // Vector bits 7:3
  logic [1:0] source_code; // Encoded source
  logic [7:0] rdap; // Receive DMA pointer
  logic rx_full; // Byte waits for reader
  logic tx_empty; // Transmitter wants byte
  logic [9:0] div_cnt; // Phase length counter
  icdr_scl_t scl_phase; // Serial clock phase
  logic req; // New bus request
  logic wr; // Register write strobe
  logic rd; // Register read strobe
  logic [7:0] idx; // Register index
  logic [7:0] rd_mux; // Read data
  logic [8:0] divider_code; // Full divider code
  logic any_err; // Any error flag
  logic err_act; // Error interrupt active
  logic rx_act; // Receive interrupt active
  logic tx_act; // Transmit interrupt active
  logic rxd_ok; // Receive DMA eligible
  logic txd_ok; // Transmit DMA eligible
  logic [2:0] win; // Winner one-hot: irq, rxd, txd
  logic [1:0] next_source; // Winning interrupt code
  logic own_hit; // Own address compare
  logic gc_hit; // General call compare

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  // Seven-bit compare, direction bit ignored, 01h never hits
  function automatic logic match7(input logic [7:0] rcv,
                                  input logic [7:0] cmp);
    match7 = (cmp != ADDR_NEVER) && (rcv != ADDR_NEVER) &&
             (rcv[7:1] == cmp[7:1]);
  endfunction : match7

  // ----------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i & sel_i[0];
  assign rd = req & ~we_i;
  assign idx = adr_i[9:2];

  // Acknowledge one cycle after a request, dropped after one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // Read multiplexer, reserved bits zero
  always_comb begin
    unique case (idx)
      IDX_DIV: rd_mux = div_reg;
      IDX_DIVX: rd_mux = {6'h00, divider_code_high};
      IDX_OAR_LO: rd_mux = own_address_low;
      IDX_OAR_HI: rd_mux = {oar_hi[7:4], 1'b0, oar_hi[2:1], 1'b0};
      IDX_DATA: rd_mux = data_byte;
      IDX_GCV: rd_mux = general_call_value;
      IDX_ISR: rd_mux = {dma_suspend_select, priority_level, 1'b0,
                         error_pending, receive_pending,
                         transmit_pending};
      IDX_IVR: rd_mux = {vector_base, source_code, 1'b0};
      IDX_RDAP: rd_mux = rdap;
      default: rd_mux = 8'h00; // Unmapped reads zero
    endcase
  end

  // Read data register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd) begin
      dat_o <= {24'h00_0000, rd_mux};
    end
  end

  // ----------------------------------------------------------
  // Clock and addressing configuration
  // ----------------------------------------------------------
  // Speed and divider, untouched by disable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= RST_ZERO;
      divider_code_high <= 2'h0;
    end else if (wr && idx == IDX_DIV) begin
      div_reg <= dat_i[7:0];
    end else if (wr && idx == IDX_DIVX) begin
      divider_code_high <= dat_i[1:0];
    end
  end

  // Own address low byte
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      own_address_low <= RST_ZERO;
    end else if (wr && idx == IDX_OAR_LO) begin
      own_address_low <= dat_i[7:0];
    end
  end

  // Range and ten-bit bits only while disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oar_hi <= RST_ZERO;
    end else if (wr && idx == IDX_OAR_HI) begin
      oar_hi[2:1] <= dat_i[2:1];
      if (!peripheral_enable_i) begin
        oar_hi[7:6] <= dat_i[7:6];
        oar_hi[OAR_F2] <= dat_i[OAR_F2];
        oar_hi[OAR_TEN] <= dat_i[OAR_TEN];
      end
    end
  end

  // General call value, locked while enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      general_call_value <= RST_GCV;
    end else if (wr && idx == IDX_GCV && !peripheral_enable_i) begin
      general_call_value <= dat_i[7:0];
    end
  end

  assign timing_range_select_o = {oar_hi[OAR_F2], oar_hi[7:6]};
  assign ten_bit_enable_o = oar_hi[OAR_TEN];

  // ----------------------------------------------------------
  // Address matching
  // ----------------------------------------------------------
  // Ten-bit or seven-bit own address compare
  always_comb begin
    if (oar_hi[OAR_TEN]) begin
      own_hit = bus_addr_ten_i &&
                (bus_addr_i == {oar_hi[2:1], own_address_low});
    end else begin
      own_hit = !bus_addr_ten_i &&
                match7(bus_addr_i[7:0], own_address_low);
    end
    gc_hit = !bus_addr_ten_i &&
             match7(bus_addr_i[7:0], general_call_value);
  end

  // Match pulses, only while enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      own_match_o <= 1'b0;
      gen_call_match_o <= 1'b0;
    end else begin
      own_match_o <= addr_valid_i & peripheral_enable_i & own_hit;
      gen_call_match_o <= addr_valid_i & peripheral_enable_i & gc_hit;
    end
  end

  // ----------------------------------------------------------
  // Serial clock generator
  // ----------------------------------------------------------
  assign divider_code = {divider_code_high, div_reg[6:0]};

  // Each phase lasts N+2 cycles; fast mode has two low phases
  always_ff @(posedge clk_i) begin
    if (rst_i || !peripheral_enable_i) begin
      div_cnt <= 10'h000;
      scl_phase <= SCL_LOW1;
      scl_tick_o <= 1'b0;
    end else if (div_cnt == {1'b0, divider_code} + 10'h001) begin
      div_cnt <= 10'h000;
      scl_tick_o <= 1'b1;
      unique case (scl_phase)
        SCL_LOW1: scl_phase <= div_reg[DIV_SPEED] ? SCL_LOW2
                                                  : SCL_HIGH;
        SCL_LOW2: scl_phase <= SCL_HIGH;
        SCL_HIGH: scl_phase <= SCL_LOW1;
        default: scl_phase <= SCL_LOW1;
      endcase
    end else begin
      div_cnt <= div_cnt + 10'h001;
      scl_tick_o <= 1'b0;
    end
  end

  // Line idles high while disabled
  assign scl_o = !peripheral_enable_i || scl_phase == SCL_HIGH;

  // ----------------------------------------------------------
  // Data path
  // ----------------------------------------------------------
  // Software write or received byte updates data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_byte <= RST_ZERO;
    end else if (wr && idx == IDX_DATA) begin
      data_byte <= dat_i[7:0];
    end else if (rx_byte_valid_i) begin
      data_byte <= rx_byte_i;
    end
  end

  assign tx_byte_o = data_byte;

  // Next-byte pulses from software or DMA completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_start_o <= 1'b0;
      rx_next_o <= 1'b0;
    end else begin
      tx_start_o <= (wr && idx == IDX_DATA) || tx_dma_done_i;
      rx_next_o <= (rd && idx == IDX_DATA) || rx_dma_done_i;
    end
  end

  // Byte-waiting flags feeding DMA requests
  always_ff @(posedge clk_i) begin
    if (rst_i || !peripheral_enable_i) begin
      rx_full <= 1'b0;
      tx_empty <= 1'b0;
    end else begin
      if (rx_byte_valid_i) begin
        rx_full <= 1'b1;
      end else if ((rd && idx == IDX_DATA) || rx_dma_done_i) begin
        rx_full <= 1'b0;
      end
      if (tx_ready_i) begin
        tx_empty <= 1'b1;
      end else if ((wr && idx == IDX_DATA) || tx_dma_done_i) begin
        tx_empty <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Pending bits and priority
  // ----------------------------------------------------------
  assign any_err = |error_flags_i;

  // Mode and priority fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dma_suspend_select <= RST_ISR[ISR_SUSP];
      priority_level <= RST_ISR[6:4];
    end else if (wr && idx == IDX_ISR) begin
      dma_suspend_select <= dat_i[ISR_SUSP];
      priority_level <= dat_i[6:4];
    end
  end

  // Error pending: set wins, held while any error flag stays
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_pending <= 1'b0;
    end else if (global_interrupt_enable_i && any_err) begin
      error_pending <= 1'b1;
    end else if (any_err) begin
      error_pending <= error_pending;
    end else if (!peripheral_enable_i) begin
      error_pending <= 1'b0;
    end else if (wr && idx == IDX_ISR && !dat_i[ISR_ERR]) begin
      error_pending <= 1'b0;
    end
  end

  // Receive and transmit pending, set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_pending <= 1'b0;
    end else if (global_interrupt_enable_i && rx_byte_valid_i) begin
      receive_pending <= 1'b1;
    end else if (!peripheral_enable_i) begin
      receive_pending <= 1'b0;
    end else if (wr && idx == IDX_ISR && !dat_i[ISR_RX]) begin
      receive_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_pending <= 1'b0;
    end else if (global_interrupt_enable_i && tx_ready_i) begin
      transmit_pending <= 1'b1;
    end else if (!peripheral_enable_i) begin
      transmit_pending <= 1'b0;
    end else if (wr && idx == IDX_ISR && !dat_i[ISR_TX]) begin
      transmit_pending <= 1'b0;
    end
  end

  assign err_act = error_pending & irq_mask_i[2];
  assign rx_act = receive_pending & irq_mask_i[1];
  assign tx_act = transmit_pending & irq_mask_i[0];
  // Suspended mode blocks DMA while an error is pending
  assign rxd_ok = rx_dma_mask_i & rx_full &
                  ~(dma_suspend_select & error_pending);
  assign txd_ok = tx_dma_mask_i & tx_empty &
                  ~(dma_suspend_select & error_pending);

  // Fixed source order; win is {irq, rx dma, tx dma}
  always_comb begin
    win = 3'b000;
    next_source = source_code;
    if (dma_suspend_select && err_act) begin
      win = 3'b100;
      next_source = SRC_ERR;
    end else if (rxd_ok) begin
      win = 3'b010;
    end else if (txd_ok) begin
      win = 3'b001;
    end else if (err_act) begin
      win = 3'b100;
      next_source = SRC_ERR;
    end else if (rx_act) begin
      win = 3'b100;
      next_source = SRC_RX;
    end else if (tx_act) begin
      win = 3'b100;
      next_source = SRC_TX;
    end
  end

  // Requests leave only when priority is not "none"
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o <= 1'b0;
      rx_dma_req_o <= 1'b0;
      tx_dma_req_o <= 1'b0;
    end else begin
      irq_req_o <= win[2] && priority_level != PRL_NONE;
      rx_dma_req_o <= win[1] && priority_level != PRL_NONE;
      tx_dma_req_o <= win[0] && priority_level != PRL_NONE;
    end
  end

  assign priority_level_o = priority_level;

  // ----------------------------------------------------------
  // Vector and receive DMA pointer
  // ----------------------------------------------------------
  // Base is software, code follows the winning interrupt
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_base <= 5'h00;
      source_code <= 2'h0;
    end else begin
      if (wr && idx == IDX_IVR) begin
        vector_base <= dat_i[7:3];
      end
      source_code <= next_source;
    end
  end

  // Pointer location and extension source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdap <= RST_ZERO;
    end else if (wr && idx == IDX_RDAP) begin
      rdap <= dat_i[7:0];
    end
  end

  assign rx_pointer_address_o = rdap[7:1];
  assign rx_pointer_ext_select_o = rdap[0];

endmodule : icdr_regs

// ===== icdr_regs_asserts.sv
// Port checker for the two-wire bus configuration block.
// Assumes one clock domain and a bind onto icdr_regs.
`timescale 1ns/1ns

module icdr_regs_asserts
  import icdr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic peripheral_enable_i,
  input wire logic addr_valid_i,
  input wire logic [9:0] bus_addr_i,
  input wire logic bus_addr_ten_i,
  input wire logic own_match_o,
  input wire logic gen_call_match_o,
  input wire logic rx_dma_done_i,
  input wire logic tx_dma_done_i,
  input wire logic rx_dma_mask_i,
  input wire logic tx_start_o,
  input wire logic rx_next_o,
  input wire logic scl_o,
  input wire logic [2:0] priority_level_o,
  input wire logic irq_req_o,
  input wire logic rx_dma_req_o,
  input wire logic tx_dma_req_o
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic take; // Bus request accepted
  logic wr_data; // Write to data byte
  logic rd_data; // Read of data byte
  assign take = cyc_i && stb_i && !ack_o;
  assign wr_data = take && we_i && sel_i[0] && adr_i[9:2] == IDX_DATA;
  assign rd_data = take && !we_i && adr_i[9:2] == IDX_DATA;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ack_one_cycle: assert property (take |=> ack_o ##1 !ack_o)
    else $error("ack is not a single cycle answer");
  a_read_high_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_tx_start_cause: assert property ((wr_data || tx_dma_done_i) |-> ##[1:2] tx_start_o)
    else $error("next byte not started");
  a_rx_next_cause: assert property ((rd_data || rx_dma_done_i) |-> ##[1:2] rx_next_o)
    else $error("next receive not started");
  a_match_cause: assert property ((own_match_o || gen_call_match_o) |-> $past(addr_valid_i))
    else $error("match without address");
  a_never_one:
    assert property ((addr_valid_i && !bus_addr_ten_i && bus_addr_i == 10'h001)
      |=> !own_match_o && !gen_call_match_o)
    else $error("address 01h answered");
  a_scl_idle_high: assert property (!peripheral_enable_i [*3] |-> scl_o)
    else $error("serial clock low while disabled");
  a_scl_low_span: assert property ($fell(scl_o) |=> !scl_o || !peripheral_enable_i)
    else $error("serial clock low phase too short");
  a_prl_no_req:
    assert property ((priority_level_o == PRL_NONE) [*3]
      |-> !irq_req_o && !rx_dma_req_o && !tx_dma_req_o)
    else $error("request at no priority");
  a_dma_mask_gate: assert property (rx_dma_req_o |-> $past(rx_dma_mask_i))
    else $error("receive DMA request while masked");
endmodule : icdr_regs_asserts

bind icdr_regs icdr_regs_asserts u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_o, .ack_o, .peripheral_enable_i, .addr_valid_i, .bus_addr_i, .bus_addr_ten_i,
  .own_match_o, .gen_call_match_o, .rx_dma_done_i, .tx_dma_done_i, .rx_dma_mask_i,
  .tx_start_o, .rx_next_o, .scl_o, .priority_level_o, .irq_req_o, .rx_dma_req_o, .tx_dma_req_o);

// ===== icdr_bus_model.sv
// Far side of the two-wire bus: addressing masters, byte source, events.
// Assumes tasks are called just after a rising clock edge.
`timescale 1ns/1ns

module icdr_bus_model (
  input wire logic clk_i,
  input wire logic own_match_i,
  input wire logic gen_call_match_i,
  output logic addr_valid_o,
  output logic [9:0] bus_addr_o,
  output logic bus_addr_ten_o,
  output logic rx_byte_valid_o,
  output logic [7:0] rx_byte_o,
  output logic tx_ready_o,
  output logic [7:0] error_flags_o
);
  // Quiet bus at start
  initial begin
    addr_valid_o = 1'b0;
    bus_addr_o = 10'h3FF;
    bus_addr_ten_o = 1'b0;
    rx_byte_valid_o = 1'b0;
    rx_byte_o = 8'hFF;
    tx_ready_o = 1'b0;
    error_flags_o = 8'h00;
  end

  // Present an address, report the answer a cycle later
  task send_addr(input logic [9:0] a, input logic ten, output logic own, output logic gen);
    addr_valid_o <= 1'b1;
    bus_addr_o <= a;
    bus_addr_ten_o <= ten;
    @(posedge clk_i);
    addr_valid_o <= 1'b0;
    bus_addr_o <= ~a; // Stale value never lingers
    @(negedge clk_i);
    own = own_match_i;
    gen = gen_call_match_i;
    @(posedge clk_i);
  endtask : send_addr

  // One received byte
  task put_byte(input logic [7:0] b);
    rx_byte_valid_o <= 1'b1;
    rx_byte_o <= b;
    @(posedge clk_i);
    rx_byte_valid_o <= 1'b0;
    rx_byte_o <= ~b;
  endtask : put_byte

  // Ready to transmit event
  task ready_pulse();
    tx_ready_o <= 1'b1;
    @(posedge clk_i);
    tx_ready_o <= 1'b0;
  endtask : ready_pulse

  // Error flags level
  task set_errors(input logic [7:0] f);
    error_flags_o <= f;
  endtask : set_errors
endmodule : icdr_bus_model

// ===== tb_i2c_config_irq_dma_regs.sv
// Self-checking bench for the configuration, interrupt and DMA block.
// Assumes icdr_pkg, the bus model and the bound checker are compiled first.
`timescale 1ns/1ns

module tb_i2c_config_irq_dma_regs;
  import icdr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h00000000, dat_o;
  logic peripheral_enable_i = 1'b0, global_interrupt_enable_i = 1'b0;
  logic rx_dma_done_i = 1'b0, tx_dma_done_i = 1'b0;
  logic rx_dma_mask_i = 1'b0, tx_dma_mask_i = 1'b0;
  logic [2:0] irq_mask_i = 3'h0;
  logic [7:0] error_flags_i, rx_byte_i, tx_byte_o, q;
  logic [9:0] bus_addr_i;
  logic ack_o, rx_byte_valid_i, tx_ready_i, addr_valid_i, bus_addr_ten_i, own, gen;
  logic scl_o, own_match_o, gen_call_match_o, tx_start_o, rx_next_o, ten_bit_enable_o;
  logic rx_dma_req_o, tx_dma_req_o, irq_req_o, rx_pointer_ext_select_o;
  logic [2:0] timing_range_select_o, priority_level_o;
  logic [6:0] rx_pointer_address_o;
  int failures = 0, check_count = 0, n;
  logic [7:0] ridx [9] = '{IDX_DIV, IDX_OAR_LO, IDX_OAR_HI, IDX_DATA, IDX_GCV, IDX_ISR,
    IDX_IVR, IDX_RDAP, IDX_DIVX};
  logic [7:0] rval [9] = '{8'h00, 8'h00, 8'h00, 8'h00, RST_GCV, RST_ISR, 8'h00, 8'h00, 8'h00};

  icdr_bus_model bus (.clk_i, .own_match_i(own_match_o), .gen_call_match_i(gen_call_match_o),
    .addr_valid_o(addr_valid_i), .bus_addr_o(bus_addr_i), .bus_addr_ten_o(bus_addr_ten_i),
    .rx_byte_valid_o(rx_byte_valid_i), .rx_byte_o(rx_byte_i), .tx_ready_o(tx_ready_i),
    .error_flags_o(error_flags_i));

  icdr_regs dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .peripheral_enable_i, .global_interrupt_enable_i, .error_flags_i, .rx_byte_valid_i,
    .rx_byte_i, .tx_ready_i, .rx_dma_done_i, .tx_dma_done_i, .rx_dma_mask_i, .tx_dma_mask_i,
    .irq_mask_i, .addr_valid_i, .bus_addr_i, .bus_addr_ten_i, .scl_o, .scl_tick_o(),
    .timing_range_select_o, .ten_bit_enable_o, .own_match_o, .gen_call_match_o, .tx_byte_o,
    .tx_start_o, .rx_next_o, .rx_dma_req_o, .tx_dma_req_o, .irq_req_o, .priority_level_o,
    .rx_pointer_address_o, .rx_pointer_ext_select_o);

  // 25 MHz clock
  always #20 clk_i = ~clk_i;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task chkn(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chkn

  // Classic single Wishbone cycle, waits for ack
  task xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 50) failures++;
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : xfer

  task wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task rd(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk8(q, exp);
  endtask : rd

  // Cycles from one rising serial clock edge to the next
  task scl_period(output int p);
    int k;
    k = 0;
    p = 0;
    while (scl_o !== 1'b0 && k < 900) begin @(negedge clk_i); k++; end
    while (scl_o !== 1'b1 && k < 900) begin @(negedge clk_i); k++; end
    while (scl_o !== 1'b0 && k < 900) begin @(negedge clk_i); k++; p++; end
    while (scl_o !== 1'b1 && k < 900) begin @(negedge clk_i); k++; p++; end
  endtask : scl_period

  task print_verdict();
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    print_verdict();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ridx[i]) rd(ridx[i], rval[i]);
    wr(8'h10, 8'h55);
    rd(8'h10, 8'h00);
    // Configuration while disabled, then locked fields checked while enabled
    wr(IDX_OAR_HI, 8'h34);
    chk8({5'h00, timing_range_select_o}, 8'h04);
    chk8({7'h00, ten_bit_enable_o}, 8'h01);
    wr(IDX_OAR_LO, 8'h5A);
    wr(IDX_RDAP, 8'hB5);
    chk8({rx_pointer_address_o, rx_pointer_ext_select_o}, 8'hB5);
    wr(IDX_GCV, 8'h00);
    peripheral_enable_i <= 1'b1;
    wr(IDX_OAR_HI, 8'hC2);
    rd(IDX_OAR_HI, 8'h32);
    chk8({5'h00, timing_range_select_o}, 8'h04);
    wr(IDX_GCV, 8'h44);
    rd(IDX_GCV, 8'h00);
    // Ten-bit matching
    bus.send_addr(10'h15A, 1'b1, own, gen);
    chk8({7'h00, own}, 8'h01);
    bus.send_addr(10'h25A, 1'b1, own, gen);
    chk8({7'h00, own}, 8'h00);
    // Seven-bit matching and general call
    peripheral_enable_i <= 1'b0;
    wr(IDX_OAR_HI, 8'h00);
    wr(IDX_OAR_LO, 8'h42);
    peripheral_enable_i <= 1'b1;
    bus.send_addr(10'h042, 1'b0, own, gen);
    chk8({7'h00, own}, 8'h01);
    bus.send_addr(10'h043, 1'b0, own, gen);
    chk8({7'h00, own}, 8'h01);
    bus.send_addr(10'h044, 1'b0, own, gen);
    chk8({7'h00, own}, 8'h00);
    bus.send_addr(10'h000, 1'b0, own, gen);
    chk8({7'h00, gen}, 8'h01);
    bus.send_addr(10'h001, 1'b0, own, gen);
    chk8({7'h00, gen}, 8'h00);
    // Data byte both ways
    wr(IDX_DATA, 8'h5C);
    chk8(tx_byte_o, 8'h5C);
    tx_dma_done_i <= 1'b1;
    @(posedge clk_i);
    tx_dma_done_i <= 1'b0;
    global_interrupt_enable_i <= 1'b1;
    bus.put_byte(8'h9E);
    rd(IDX_DATA, 8'h9E);
    bus.ready_pulse();
    rd(IDX_ISR, 8'h83);
    wr(IDX_ISR, 8'h81);
    rd(IDX_ISR, 8'h81);
    peripheral_enable_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd(IDX_ISR, 8'h80);
    peripheral_enable_i <= 1'b1;
    // Error pending, vector, priority
    wr(IDX_IVR, 8'hAF);
    irq_mask_i <= 3'h4;
    bus.set_errors(8'h04);
    repeat (3) @(posedge clk_i);
    rd(IDX_ISR, 8'h84);
    wr(IDX_ISR, 8'h80);
    rd(IDX_ISR, 8'h84);
    rd(IDX_IVR, 8'hAA);
    chk8({7'h00, irq_req_o}, 8'h01);
    wr(IDX_ISR, 8'hF4);
    repeat (3) @(posedge clk_i);
    chk8({7'h00, irq_req_o}, 8'h00);
    // DMA suspension
    wr(IDX_ISR, 8'h84);
    rx_dma_mask_i <= 1'b1;
    bus.put_byte(8'h11);
    repeat (3) @(posedge clk_i);
    chk8({7'h00, rx_dma_req_o}, 8'h00);
    wr(IDX_ISR, 8'h04);
    repeat (3) @(posedge clk_i);
    chk8({7'h00, rx_dma_req_o}, 8'h01);
    rx_dma_done_i <= 1'b1;
    @(posedge clk_i);
    rx_dma_done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk8({7'h00, rx_dma_req_o}, 8'h00);
    rx_dma_mask_i <= 1'b0;
    irq_mask_i <= 3'h0;
    bus.set_errors(8'h00);
    wr(IDX_ISR, 8'h00);
    rd(IDX_ISR, 8'h00);
    // Serial clock divider
    wr(IDX_DIV, 8'h03);
    scl_period(n);
    chkn(n, 2 * (3 + 2));
    wr(IDX_DIV, 8'h83);
    scl_period(n);
    chkn(n, 3 * (3 + 2));
    wr(IDX_DIVX, 8'h01);
    wr(IDX_DIV, 8'h00);
    scl_period(n);
    chkn(n, 2 * (128 + 2));
    peripheral_enable_i <= 1'b0;
    rd(IDX_DIV, 8'h00);
    rd(IDX_DIVX, 8'h01);
    print_verdict();
  end
endmodule : tb_i2c_config_irq_dma_regs
